//--- scir_pkg.sv
// Package for the system control identity, interrupt state and reset registers
package scir_pkg;

  // Register byte offsets within the bank
  localparam logic [3:0] SCIR_OFF_IDENTITY = 4'h0;
  localparam logic [3:0] SCIR_OFF_ICS = 4'h4;
  localparam logic [3:0] SCIR_OFF_VTO = 4'h8;
  localparam logic [3:0] SCIR_OFF_AIRC = 4'hC;
  localparam int SCIR_ADDR_W = 4;

  // Identity fields, values arbitrary
  localparam logic [7:0] SCIR_ID_IMPL = 8'h5A;
  localparam logic [3:0] SCIR_ID_VARIANT = 4'h1;
  localparam logic [3:0] SCIR_ID_CONST = 4'hF;
  localparam logic [11:0] SCIR_ID_PART = 12'h123;
  localparam logic [3:0] SCIR_ID_REV = 4'h1;

  // Interrupt control/state bit positions
  localparam int SCIR_ICS_DS_SET = 28;
  localparam int SCIR_ICS_DS_CLR = 27;
  localparam int SCIR_ICS_TK_SET = 26;
  localparam int SCIR_ICS_TK_CLR = 25;
  localparam int SCIR_ICS_DBG = 23;
  localparam int SCIR_ICS_ANY = 22;
  localparam int SCIR_ICS_PEND_LSB = 12;
  localparam int SCIR_ICS_SINGLE = 11;
  localparam int SCIR_EXC_W = 9;
  localparam int SCIR_PEND_W = 10;

  // Vector table offset field
  localparam int SCIR_VTO_LSB = 7;
  localparam int SCIR_VTO_MSB = 29;

  // Interrupt/reset control fields
  localparam logic [15:0] SCIR_KEY_WRITE = 16'h05FA;
  localparam logic [15:0] SCIR_KEY_READ = 16'hFA05;
  localparam int SCIR_KEY_LSB = 16;
  localparam int SCIR_ORDER_BIT = 15;
  localparam int SCIR_SPLIT_LSB = 8;
  localparam int SCIR_SPLIT_W = 3;
  localparam int SCIR_RST_BIT = 2;

  // Exception numbers of the two software-pendable exceptions and of the first external interrupt
  localparam logic [8:0] SCIR_EXC_DS = 9'h00E;
  localparam logic [8:0] SCIR_EXC_TK = 9'h00F;
  localparam logic [8:0] SCIR_EXC_IRQ0 = 9'h010;

  // Status coming from the core's exception logic
  typedef struct packed {
    logic [8:0] interrupt_program_status_num;      // interrupt_program_status low bits
    logic [8:0] top_num;       // top pending enabled, before base and fault masks
    logic [7:0] top_prio;      // priority of that exception
    logic top_valid;           // a pending enabled exception exists
    logic irq_pending;         // any external interrupt pending
    logic preempted;           // preempted active exceptions remain
    logic in_debug;            // core halted in debug
    logic dbg_pending_svc;     // debug view of pending service
    logic [7:0] base_priority_mask;
    logic fault_mask_register;
  } scir_core_stat_t;

  // Control presented to the core
  typedef struct packed {
    logic deferred_service_pending;
    logic tick_pending;
    logic [22:0] table_offset_field;
    logic [2:0] priority_split_point;
    logic [7:0] group_mask;
    logic data_byte_order;
  } scir_core_ctrl_t;

endpackage : scir_pkg

//--- scir_regs.sv
// System control register bank: identity, interrupt state, table offset, reset control
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps

// Notes on behaviour
// - Identity register read-only, fixed fields
// - Deferred-service set bit pends, reads pending
// - Only software write pends deferred service
// - Deferred-service clear bit removes pending
// - Tick set bit pends, reads pending
// - Tick clear removes pending; read undefined
// - Debug bit reads zero outside debug
// - Any-interrupt flag, faults excluded
// - Top pending enabled exception number, else zero
// - Pending number honours base and fault masks
// - Single-active bit low when preempted remain
// - Running exception number, zero in thread
// - Running number equals status low nine bits
// - Table offset holds bits 29 to 7
// - Offset bit 29 selects code or SRAM
// - Keyed writes only; key reads back swapped
// - Byte order bit loaded from input at reset; here on the first clock after reset release
// - Priority split field read/write
// - Reset request bit pulses, reads zero
// - Split codes define group priority bits
module scir_regs
  import scir_pkg::*;
#(
  parameter int ADDR_W = SCIR_ADDR_W
)
(
  input wire logic sys_clk,                       // core clock
  input wire logic rstn,                          // async reset, active low
  input wire logic [ADDR_W-1:0] avs_address,      // byte address
  input wire logic avs_read,                      // read request
  input wire logic avs_write,                     // write request
  input wire logic [31:0] avs_writedata,          // write data
  input wire logic [3:0] avs_byteenable,          // byte enables
  output logic [31:0] avs_readdata,               // read data
  output logic avs_waitrequest,                   // stall
  output logic [1:0] avs_response,                // 00 ok, 10 slave error
  input wire scir_core_stat_t core_stat,          // exception logic status
  input wire logic tick_event,                    // system tick pend pulse
  input wire logic ds_taken,                      // core entered deferred service
  input wire logic tick_taken,                    // core entered tick handler
  input wire logic byte_order_config_input,       // big-endian strap
  output scir_core_ctrl_t core_ctrl_ff,           // control to the core
  output logic system_reset_request_ff            // one-cycle reset request
);

  logic ds_pend_ff;
  logic tk_pend_ff;
  logic [22:0] tbl_off_ff;
  logic [2:0] split_ff;
  logic order_ff;
  logic rst_seen_ff;
  logic ack_ff;
  logic [31:0] nxt_rdata;
  logic nxt_err;
  logic wr_go;
  logic rd_go;
  logic [31:0] wmask;
  logic [31:0] wdata;

  // Register index decode, shared by read and write paths
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [1:0] s;
    s = a[3:2];
    return s;
  endfunction : reg_sel

  function automatic logic aligned(input logic [ADDR_W-1:0] a);
    logic ok;
    ok = (a[1:0] == 2'h0);
    return ok;
  endfunction : aligned

  // Group mask from split code: codes below 3 behave as 3
  function automatic logic [7:0] grp_mask(input logic [2:0] c);
    logic [7:0] m;
    case (c)
      3'h4: m = 8'hE0;
      3'h5: m = 8'hC0;
      3'h6: m = 8'h80;
      3'h7: m = 8'h00;
      default: m = 8'hF0;
    endcase
    return m;
  endfunction : grp_mask

  // Bus takes one wait cycle, then answers
  assign wr_go = avs_write && !ack_ff;
  assign rd_go = avs_read && !ack_ff;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
    wdata = avs_writedata & wmask;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= (avs_read || avs_write) && !ack_ff;
    end
  end

  // Registered copy of !ack_ff so the stall output comes from a flop
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_ff);
    end
  end

  // Write is committed at the acknowledging edge only
  logic wr_commit;
  logic sel_ics;
  logic sel_vto;
  logic sel_airc;
  logic key_ok;
  assign wr_commit = avs_write && ack_ff && aligned(avs_address);
  assign sel_ics = reg_sel(avs_address) == SCIR_OFF_ICS[3:2];
  assign sel_vto = reg_sel(avs_address) == SCIR_OFF_VTO[3:2];
  assign sel_airc = reg_sel(avs_address) == SCIR_OFF_AIRC[3:2];
  // Key must be fully written in both upper lanes
  assign key_ok = (avs_writedata[31:SCIR_KEY_LSB] == SCIR_KEY_WRITE)
                  && (avs_byteenable[3:2] == 2'h3);

  // Deferred service: software is the only setter; set beats clear
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ds_pend_ff <= 1'b0;
    end
    else if (wr_commit && sel_ics && wdata[SCIR_ICS_DS_SET])
    begin
      ds_pend_ff <= 1'b1;
    end
    else if ((wr_commit && sel_ics && wdata[SCIR_ICS_DS_CLR]) || ds_taken)
    begin
      ds_pend_ff <= 1'b0;
    end
  end

  // Tick pending: hardware tick or software set, set beats clear
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tk_pend_ff <= 1'b0;
    end
    else if (tick_event || (wr_commit && sel_ics && wdata[SCIR_ICS_TK_SET]))
    begin
      tk_pend_ff <= 1'b1;
    end
    else if ((wr_commit && sel_ics && wdata[SCIR_ICS_TK_CLR]) || tick_taken)
    begin
      tk_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tbl_off_ff <= '0;
    end
    else if (wr_commit && sel_vto)
    begin
      // Masked per byte lane; low seven offset bits are not stored
      tbl_off_ff <= (tbl_off_ff & ~wmask[SCIR_VTO_MSB:SCIR_VTO_LSB])
                    | wdata[SCIR_VTO_MSB:SCIR_VTO_LSB];
    end
  end

  // Split field kept only on keyed write that enables its lane
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      split_ff <= '0;
    end
    else if (wr_commit && sel_airc && key_ok && avs_byteenable[1])
    begin
      split_ff <= avs_writedata[SCIR_SPLIT_LSB +: SCIR_SPLIT_W];
    end
  end

  // Reset request is a single pulse; wrong key raises nothing
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      system_reset_request_ff <= 1'b0;
    end
    else
    begin
      system_reset_request_ff <= wr_commit && sel_airc && key_ok
                                 && wdata[SCIR_RST_BIT];
    end
  end

  // Low until the first clock after reset release; gates the strap capture
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_seen_ff <= 1'b0;
    end
    else
    begin
      rst_seen_ff <= 1'b1;
    end
  end

  // Strap is static; first clocked cycle after release latches it
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      order_ff <= 1'b0;
    end
    else if (!rst_seen_ff)
    begin
      order_ff <= byte_order_config_input;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      core_ctrl_ff <= '0;
    end
    else
    begin
      core_ctrl_ff.deferred_service_pending <= ds_pend_ff;
      core_ctrl_ff.tick_pending <= tk_pend_ff;
      core_ctrl_ff.table_offset_field <= tbl_off_ff;
      core_ctrl_ff.priority_split_point <= split_ff;
      core_ctrl_ff.group_mask <= grp_mask(split_ff);
      core_ctrl_ff.data_byte_order <= order_ff;
    end
  end

  // Top pending number after base-priority and fault masks
  logic [8:0] top_num;
  logic masked;
  always_comb
  begin
    masked = core_stat.fault_mask_register
             || ((core_stat.base_priority_mask != 8'h00)
                 && ((core_stat.top_prio & grp_mask(split_ff))
                     >= (core_stat.base_priority_mask & grp_mask(split_ff))));
    // Main mask deliberately not considered here
    top_num = (core_stat.top_valid && !masked) ? core_stat.top_num : 9'h000;
  end

  // Read data; reserved bits stay zero
  always_comb
  begin
    nxt_rdata = '0;
    nxt_err = !aligned(avs_address);
    case (reg_sel(avs_address))
      2'h0:
      begin
        nxt_rdata = {SCIR_ID_IMPL, SCIR_ID_VARIANT, SCIR_ID_CONST,
                     SCIR_ID_PART, SCIR_ID_REV};
      end
      2'h1:
      begin
        nxt_rdata[SCIR_ICS_DS_SET] = ds_pend_ff;
        nxt_rdata[SCIR_ICS_TK_SET] = tk_pend_ff;
        nxt_rdata[SCIR_ICS_DBG] = core_stat.in_debug && core_stat.dbg_pending_svc;
        nxt_rdata[SCIR_ICS_ANY] = core_stat.irq_pending;
        nxt_rdata[SCIR_ICS_PEND_LSB +: SCIR_PEND_W] = {1'b0, top_num};
        nxt_rdata[SCIR_ICS_SINGLE] = !core_stat.preempted;
        nxt_rdata[SCIR_EXC_W-1:0] = core_stat.interrupt_program_status_num;
      end
      2'h2:
      begin
        nxt_rdata[SCIR_VTO_MSB:SCIR_VTO_LSB] = tbl_off_ff;
      end
      2'h3:
      begin
        nxt_rdata[31:SCIR_KEY_LSB] = SCIR_KEY_READ;
        nxt_rdata[SCIR_ORDER_BIT] = order_ff;
        nxt_rdata[SCIR_SPLIT_LSB +: SCIR_SPLIT_W] = split_ff;
        // Reset request and debug-only bits read zero
      end
      default:
      begin
        nxt_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      avs_readdata <= '0;
      avs_response <= 2'h0;
    end
    else if (rd_go || wr_go)
    begin
      avs_readdata <= rd_go ? nxt_rdata : 32'h0000_0000;
      avs_response <= nxt_err ? 2'h2 : 2'h0;
    end
  end

endmodule : scir_regs

//--- scir_regs_chk_sva.sv
// Concurrent checks on the ports of the system control register bank
`timescale 1ns/1ps
module scir_regs_chk
  import scir_pkg::*;
#(
  parameter int ADDR_W = 4
)
(
  input logic sys_clk, // core clock
  input logic rstn, // async reset, active low
  input logic [ADDR_W-1:0] avs_address, // byte address
  input logic avs_read, // read request
  input logic avs_write, // write request
  input logic [31:0] avs_writedata, // write data
  input logic [31:0] avs_readdata, // read data
  input logic avs_waitrequest, // stall
  input logic [1:0] avs_response, // response code
  input scir_core_stat_t core_stat, // core status
  input logic system_reset_request_ff // reset request pulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic done;
  logic rd4;
  assign done = (avs_read | avs_write) & !avs_waitrequest;
  assign rd4 = done & avs_read & (avs_address == SCIR_OFF_ICS);
  wait_one_a: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  ans_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
  id_read_a: assert property (done && avs_read && avs_address == SCIR_OFF_IDENTITY |->
    avs_readdata == {SCIR_ID_IMPL, SCIR_ID_VARIANT, SCIR_ID_CONST, SCIR_ID_PART, SCIR_ID_REV})
    else $error("identity read wrong");
  key_read_a: assert property (done && avs_read && avs_address == SCIR_OFF_AIRC |->
    avs_readdata[31:16] == SCIR_KEY_READ && avs_readdata[14:11] == 4'h0 && avs_readdata[7:0] == 8'h00)
    else $error("reset control read wrong");
  vto_zero_a: assert property (done && avs_read && avs_address == SCIR_OFF_VTO |->
    avs_readdata[31:30] == 2'h0 && avs_readdata[6:0] == 7'h00) else $error("table offset low bits set");
  active_num_a: assert property (rd4 |-> avs_readdata[8:0] == $past(core_stat.interrupt_program_status_num))
    else $error("running exception number wrong");
  irq_flag_a: assert property (rd4 |-> avs_readdata[22] == $past(core_stat.irq_pending))
    else $error("interrupt waiting flag wrong");
  dbg_zero_a: assert property (rd4 && !$past(core_stat.in_debug) |-> !avs_readdata[23])
    else $error("debug bit set outside debug");
  single_act_a: assert property (rd4 |-> avs_readdata[11] == !$past(core_stat.preempted))
    else $error("single active bit wrong");
  fault_hide_a: assert property (rd4 && $past(core_stat.fault_mask_register) |->
    avs_readdata[21:12] == 10'h000) else $error("pending number ignores fault mask");
  misalign_a: assert property (done && avs_address[1:0] != 2'h0 |-> avs_response == 2'h2)
    else $error("misaligned access not refused");
  rst_once_a: assert property (system_reset_request_ff |=> !system_reset_request_ff)
    else $error("reset request longer than one cycle");
  rst_cause_a: assert property (system_reset_request_ff |-> $past(done && avs_write &&
    avs_address == SCIR_OFF_AIRC && avs_writedata[31:16] == SCIR_KEY_WRITE && avs_writedata[2]))
    else $error("reset request without keyed write");
  cover property (system_reset_request_ff);
  cover property (rd4 && core_stat.fault_mask_register);
  cover property (done && avs_address[1:0] != 2'h0);
endmodule : scir_regs_chk

//--- scir_core_model.sv
// Behavioural model of the core exception logic facing the register bank
`timescale 1ns/1ps
module scir_core_model
  import scir_pkg::*;
(
  input logic sys_clk, // core clock
  input logic rstn, // async reset, active low
  input scir_core_stat_t stat_req, // status a scenario asks for
  input logic [2:0] pulse_req, // tick event, ds taken, tick taken
  output scir_core_stat_t core_stat, // status to the bank
  output logic tick_event, // tick pend pulse
  output logic ds_taken, // deferred service entered
  output logic tick_taken // tick handler entered
);
  // Registered, so status never moves in mid-cycle as a real core's would not
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      core_stat <= '0;
      {tick_event, ds_taken, tick_taken} <= 3'h0;
    end
    else
    begin
      core_stat <= stat_req;
      {tick_event, ds_taken, tick_taken} <= pulse_req;
    end
  end
endmodule : scir_core_model

//--- scir_tb.sv
// Self-checking bench for the system control register bank
`timescale 1ns/1ps
module testbench;
  import scir_pkg::*;
  typedef struct {logic we; logic [3:0] a; logic [31:0] wd; logic [31:0] m; logic [31:0] ex;} scir_row_t;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, tick_event, ds_taken, tick_taken, rst_req;
  logic [1:0] avs_response, rsp;
  logic strap = 1'b0;
  logic [2:0] pulse_req = 3'h0;
  scir_core_stat_t core_stat;
  scir_core_ctrl_t ctrl;
  scir_core_stat_t stat_req = '{interrupt_program_status_num: 9'h013, top_num: 9'h012, top_prio: 8'h40,
    top_valid: 1'b1, irq_pending: 1'b1, default: '0};
  int n_errors = 0;
  int tests_run = 0;
  int n_pulse = 0;
  // Rows never write set and clear of one exception together
  // Table offsets written include all ones, whose low seven bits are not stored
  scir_row_t rows[14] = '{'{0, 4'hC, 0, 32'hFFFFFFFF, 32'hFA050000}, '{0, 4'h8, 0, 32'hFFFFFFFF, 0},
    '{1, 4'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h5A1F1231}, '{1, 4'h8, 32'hFFFFFFFF, 32'hFFFFFFFF,
    32'h3FFFFF80}, '{1, 4'h8, 32'h20000000, 32'hFFFFFFFF, 32'h20000000}, '{1, 4'hC, 32'h05FA0700,
    32'hFFFFFFFF, 32'hFA050700}, '{1, 4'hC, 32'h12340300, 32'hFFFFFFFF, 32'hFA050700}, '{1, 4'hC,
    32'h05FA0300, 32'hFFFFFFFF, 32'hFA050300}, '{0, 4'h4, 0, 32'hF5FFFFFF, 32'h00412813}, '{1, 4'h4,
    32'h10000000, 32'h10000000, 32'h10000000}, '{1, 4'h4, 0, 32'h10000000, 32'h10000000}, '{1, 4'h4,
    32'h08000000, 32'h10000000, 0}, '{1, 4'h4, 32'h04000000, 32'h04000000, 32'h04000000}, '{1, 4'h4,
    32'h02000000, 32'h04000000, 0}};
  `define CHK(nm, e, g) chk(nm, e, g)
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (rst_req === 1'b1) n_pulse++;
  scir_core_model u_core (.sys_clk(sys_clk), .rstn(rstn), .stat_req(stat_req),
    .pulse_req(pulse_req), .core_stat(core_stat), .tick_event(tick_event), .ds_taken(ds_taken),
    .tick_taken(tick_taken));
  scir_regs #(.ADDR_W(4)) dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .core_stat(core_stat), .tick_event(tick_event),
    .ds_taken(ds_taken), .tick_taken(tick_taken), .byte_order_config_input(strap),
    .core_ctrl_ff(ctrl), .system_reset_request_ff(rst_req));
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_read <= !we;
    avs_write <= we;
    avs_address <= a;
    avs_writedata <= wd;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      n_errors++;
      stop_test();
    end
  endtask : bus
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask : do_reset
  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      if (rows[i].we)
        bus(1'b1, rows[i].a, rows[i].wd);
      bus(1'b0, rows[i].a, 32'h0);
      `CHK("row", rows[i].ex, rd & rows[i].m);
    end
    // Misaligned write must leave the offset alone
    bus(1'b1, 4'h9, 32'h00000080);
    `CHK("misaligned_resp", 32'h2, {30'h0, rsp});
    bus(1'b0, 4'h8, 32'h0);
    `CHK("misaligned_effect", 32'h20000000, rd);
    bus(1'b1, 4'hC, 32'h05FA0500);
    repeat (2) @(posedge sys_clk);
    `CHK("group_mask", 32'hC0, {24'h0, ctrl.group_mask});
    `CHK("split_out", 32'h5, {29'h0, ctrl.priority_split_point});
    `CHK("table_out", 32'h00400000, {9'h0, ctrl.table_offset_field});
    bus(1'b1, 4'hC, 32'h05FA0004);
    repeat (4) @(posedge sys_clk);
    `CHK("reset_pulse", 32'h1, n_pulse);
    bus(1'b1, 4'hC, 32'h12340004);
    repeat (4) @(posedge sys_clk);
    `CHK("reset_badkey", 32'h1, n_pulse);
    pulse_req <= 3'h4;
    @(posedge sys_clk);
    pulse_req <= 3'h0;
    bus(1'b0, 4'h4, 32'h0);
    `CHK("tick_hw", 32'h04000000, rd & 32'h14000000);
    pulse_req <= 3'h1;
    @(posedge sys_clk);
    pulse_req <= 3'h0;
    bus(1'b0, 4'h4, 32'h0);
    `CHK("tick_taken", 32'h0, rd & 32'h04000000);
    stat_req.fault_mask_register <= 1'b1;
    bus(1'b0, 4'h4, 32'h0);
    `CHK("pend_fault", 32'h0, rd & 32'h003FF000);
    stat_req.fault_mask_register <= 1'b0;
    stat_req.base_priority_mask <= 8'h40;
    bus(1'b0, 4'h4, 32'h0);
    `CHK("pend_base_hide", 32'h0, rd & 32'h003FF000);
    stat_req.base_priority_mask <= 8'h80;
    bus(1'b0, 4'h4, 32'h0);
    `CHK("pend_base_pass", 32'h00012000, rd & 32'h003FF000);
    // Second reset in mid-run with the strap flipped
    strap <= 1'b1;
    do_reset();
    bus(1'b0, 4'hC, 32'h0);
    `CHK("byte_order", 32'hFA058000, rd);
    stop_test();
  end
endmodule : testbench
bind scir_regs scir_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.sys_clk(sys_clk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .core_stat(core_stat),
  .system_reset_request_ff(system_reset_request_ff));
